// file: design/ai_timing_cfg.svh
`ifndef AI_TIMING_CFG_SVH
`define AI_TIMING_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define AIT_SEL_W       4
`define AIT_CNT_W       16
`define AIT_BUS_W       16

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define AIT_CLK_NS      100
`define AIT_EXT_DLY_NS  200
`define AIT_EXT_DLY_CYC ((`AIT_EXT_DLY_NS + `AIT_CLK_NS - 1) / `AIT_CLK_NS)

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AIT_CNT_RST     16'h0000

`endif

// file: design/ai_timing_pkg.sv
`include "ai_timing_cfg.svh"

package ai_timing_pkg;

    // ------------------------------------------------------------
    // Static configuration, held stable while armed
    // ------------------------------------------------------------
    typedef struct packed {
        logic                  use_div;
        logic                  samp_ext;
        logic                  ref_en;
        logic                  export_en;
        logic [`AIT_SEL_W-1:0] conv_tb_sel;
        logic [`AIT_SEL_W-1:0] samp_tb_sel;
        logic [`AIT_SEL_W-1:0] samp_clk_sel;
        logic [`AIT_SEL_W-1:0] start_sel;
        logic [`AIT_SEL_W-1:0] ref_sel;
        logic [`AIT_SEL_W-1:0] pause_sel;
        logic [`AIT_CNT_W-1:0] conv_div;
        logic [`AIT_CNT_W-1:0] samp_div;
        logic [`AIT_CNT_W-1:0] conv_per_samp;
        logic [`AIT_CNT_W-1:0] post_cnt;
    } cfg_t;

    // ------------------------------------------------------------
    // State machines
    // ------------------------------------------------------------
    typedef enum logic [1:0] {C_IDLE, C_WAIT, C_CONV, C_DONE} conv_st_t;
    typedef enum logic       {S_IDLE, S_RUN} samp_st_t;

endpackage : ai_timing_pkg

// file: design/analog_input_timing_engine.sv
`timescale 1ns/10ps
// Function
// R01 - Each sample clock launches one or more converts
// R02 - Divided mode: sync companion is inverted timebase
// R03 - Free-running: capture triggers on timebase fall
// R04 - External convert: sync raw, timebase delayed copy
// R05 - Sample sync clock is inverted sample timebase
// R06 - Sample clock from divider or other source
// R07 - Tally, ratio, interval counters on convert timebase
// R08 - Level crossings are synchronized
// R09 - Stop after reference and posttrigger samples
// R10 - Start chosen by mux, then synchronized
// R11 - Synchronized pause trigger suspends acquisition
// R12 - Conversion pulse drives converter, copy exported
// R13 - Timebases selected from shared signal bus
// R14 - Converts wait for sample clock after start
// R15 - Count posttrigger amount, then stop
// R16 - Pause holds sample clocks, counters kept
// R17 - Trigger registered on sync edge, used later

`include "ai_timing_cfg.svh"

module analog_input_timing_engine #(
    parameter int BUS_W = `AIT_BUS_W
) (
    input  wire logic               sys_clk,
    input  wire logic               resetn,
    input  wire logic               arm,
    input  wire logic               sw_start,
    input  wire logic [BUS_W-1:0]   signal_bus,
    input  wire ai_timing_pkg::cfg_t cfg,
    output logic                    adc_conversion_pulse,
    output logic                    export_drive_node,
    output logic                    running,
    output logic                    done
);
    import ai_timing_pkg::*;
    localparam int DLY = `AIT_EXT_DLY_CYC;
    // Selector must reach every line and the bus needs at least two lines
    if (BUS_W < 2 || BUS_W > (1 << `AIT_SEL_W)) begin : g_bus_w_chk
        $error("BUS_W out of range");
    end

    // Pick one line of the signal bus, unused indices read zero
    function automatic logic pick(input logic [BUS_W-1:0] bus,
                                  input logic [`AIT_SEL_W-1:0] sel);
        return (int'(sel) < BUS_W) ? bus[sel] : 1'b0;
    endfunction : pick

    // ------------------------------------------------------------
    // Timebases and companion sync clocks
    // ------------------------------------------------------------
    logic           craw_prev_r, craw_prev_nxt;
    logic           ctb_prev_r, ctb_prev_nxt;
    logic           sraw_prev_r, sraw_prev_nxt;
    logic [DLY-1:0] dly_r, dly_nxt;
    logic           raw_c, raw_s, ctb;
    logic           c_act, c_sync, s_act, s_sync;
    // Edge decode of both timing levels
    always_comb begin
        raw_c         = pick(signal_bus, cfg.conv_tb_sel);   // R13
        raw_s         = pick(signal_bus, cfg.samp_tb_sel);   // R13
        dly_nxt       = {dly_r[DLY-2:0], raw_c};             // R04
        ctb           = cfg.use_div ? raw_c : dly_r[DLY-1];  // R04
        c_act         = ctb & ~ctb_prev_r;
        // Divided: sync rises when timebase falls
        c_sync        = cfg.use_div ? (~raw_c & craw_prev_r)  // R02 R03
                                    : (raw_c & ~craw_prev_r); // R04
        s_act         = raw_s & ~sraw_prev_r;
        s_sync        = ~raw_s & sraw_prev_r;                 // R05
        craw_prev_nxt = raw_c;
        ctb_prev_nxt  = ctb;
        sraw_prev_nxt = raw_s;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            craw_prev_r <= 1'b0;
            ctb_prev_r  <= 1'b0;
            sraw_prev_r <= 1'b0;
            dly_r       <= '0;
        end else begin
            craw_prev_r <= craw_prev_nxt;
            ctb_prev_r  <= ctb_prev_nxt;
            sraw_prev_r <= sraw_prev_nxt;
            dly_r       <= dly_nxt;
        end
    end

    // ------------------------------------------------------------
    // Selected start
    // ------------------------------------------------------------
    logic sw_pend_r, sw_pend_nxt;
    logic sel_start;
    // Software start held until disarm so both levels see it
    always_comb begin
        sw_pend_nxt = arm & (sw_pend_r | sw_start);
        sel_start   = pick(signal_bus, cfg.start_sel) | sw_pend_r; // R10
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn)
            sw_pend_r <= 1'b0;
        else
            sw_pend_r <= sw_pend_nxt;
    end

    // ------------------------------------------------------------
    // Sample level
    // ------------------------------------------------------------
    samp_st_t              s_st_r, s_st_nxt;
    logic                  st_s_r, st_s_nxt;
    logic                  pause_s_r, pause_s_nxt;
    logic [`AIT_CNT_W-1:0] si_cnt_r, si_cnt_nxt;
    logic                  samp_tog_r, samp_tog_nxt;
    logic                  sclk_prev_r, sclk_prev_nxt;
    logic                  ext_clk, samp_evt;
    logic                  c_done;
    // Sample clock generation from divider or external line
    always_comb begin
        s_st_nxt      = s_st_r;
        st_s_nxt      = s_sync ? sel_start : st_s_r;           // R17
        pause_s_nxt   = s_sync ? pick(signal_bus, cfg.pause_sel)
                               : pause_s_r;                    // R11
        si_cnt_nxt    = si_cnt_r;
        ext_clk       = pick(signal_bus, cfg.samp_clk_sel);
        sclk_prev_nxt = ext_clk;
        samp_evt      = 1'b0;
        case (s_st_r)
            S_IDLE: begin
                if (arm && s_act && st_s_r && !pause_s_r) begin // R14 R16
                    s_st_nxt   = S_RUN;
                    si_cnt_nxt = cfg.samp_div - 16'h0001;
                end
            end
            S_RUN: begin
                if (cfg.samp_ext) begin
                    samp_evt = ext_clk & ~sclk_prev_r
                               & ~pause_s_r;                   // R06 R16
                end else if (s_act && !pause_s_r) begin        // R16
                    if (si_cnt_r == '0) begin
                        samp_evt   = 1'b1;                     // R06
                        si_cnt_nxt = cfg.samp_div - 16'h0001;
                    end else begin
                        si_cnt_nxt = si_cnt_r - 16'h0001;
                    end
                end
            end
            default: s_st_nxt = S_IDLE;
        endcase
        if (!arm || c_done) begin
            s_st_nxt = S_IDLE;
            st_s_nxt = 1'b0;
            samp_evt = 1'b0;  // No late sample while stopping
        end
        samp_tog_nxt = samp_tog_r ^ samp_evt;                  // R08
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_st_r      <= S_IDLE;
            st_s_r      <= 1'b0;
            pause_s_r   <= 1'b0;
            si_cnt_r    <= `AIT_CNT_RST;
            samp_tog_r  <= 1'b0;
            sclk_prev_r <= 1'b0;
        end else begin
            s_st_r      <= s_st_nxt;
            st_s_r      <= st_s_nxt;
            pause_s_r   <= pause_s_nxt;
            si_cnt_r    <= si_cnt_nxt;
            samp_tog_r  <= samp_tog_nxt;
            sclk_prev_r <= sclk_prev_nxt;
        end
    end

    // ------------------------------------------------------------
    // Convert level
    // ------------------------------------------------------------
    conv_st_t              c_st_r, c_st_nxt;
    logic                  st_c_r, st_c_nxt;
    logic                  ref_c_r, ref_c_nxt;
    logic                  tog_c_r, tog_c_nxt;
    logic                  ack_r, ack_nxt;
    logic                  ref_seen_r, ref_seen_nxt;
    logic [`AIT_CNT_W-1:0] ratio_r, ratio_nxt;
    logic [`AIT_CNT_W-1:0] int_r, int_nxt;
    logic [`AIT_CNT_W-1:0] tally_r, tally_nxt;
    logic                  pulse_nxt;

    assign c_done = (c_st_r == C_DONE);
    // Convert sequencing on the convert timebase
    always_comb begin
        c_st_nxt     = c_st_r;
        st_c_nxt     = c_sync ? sel_start : st_c_r;            // R10 R17
        ref_c_nxt    = c_sync ? pick(signal_bus, cfg.ref_sel)
                              : ref_c_r;                       // R17
        tog_c_nxt    = c_sync ? samp_tog_r : tog_c_r;          // R08
        ack_nxt      = ack_r;
        ref_seen_nxt = ref_seen_r;
        ratio_nxt    = ratio_r;
        int_nxt      = int_r;
        tally_nxt    = tally_r;
        pulse_nxt    = 1'b0;
        if (c_act) begin                                       // R07
            if (cfg.ref_en && ref_c_r &&
                (c_st_r == C_WAIT || c_st_r == C_CONV))
                ref_seen_nxt = 1'b1;                           // R09
            case (c_st_r)
                C_IDLE: begin
                    if (arm && st_c_r) begin
                        c_st_nxt = C_WAIT;
                        ack_nxt  = tog_c_r;
                    end
                end
                C_WAIT: begin
                    if (tog_c_r != ack_r) begin                // R14
                        ack_nxt   = tog_c_r;
                        c_st_nxt  = C_CONV;
                        ratio_nxt = cfg.conv_per_samp;         // R01
                        int_nxt   = '0;
                    end
                end
                C_CONV: begin
                    if (!cfg.use_div || int_r == '0) begin
                        pulse_nxt = 1'b1;                      // R01
                        int_nxt   = cfg.conv_div - 16'h0001;
                        ratio_nxt = ratio_r - 16'h0001;
                        if (ratio_r <= 16'h0001) begin
                            c_st_nxt = C_WAIT;
                            if (ref_seen_r) begin
                                tally_nxt = tally_r + 16'h0001;
                                if (tally_nxt >= cfg.post_cnt)
                                    c_st_nxt = C_DONE;         // R15
                            end
                        end
                    end else begin
                        int_nxt = int_r - 16'h0001;
                    end
                end
                C_DONE: c_st_nxt = C_DONE;
                default: c_st_nxt = C_IDLE;
            endcase
        end
        if (!arm) begin
            c_st_nxt     = C_IDLE;
            st_c_nxt     = 1'b0;
            ref_seen_nxt = 1'b0;
            tally_nxt    = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            c_st_r     <= C_IDLE;
            st_c_r     <= 1'b0;
            ref_c_r    <= 1'b0;
            tog_c_r    <= 1'b0;
            ack_r      <= 1'b0;
            ref_seen_r <= 1'b0;
            ratio_r    <= `AIT_CNT_RST;
            int_r      <= `AIT_CNT_RST;
            tally_r    <= `AIT_CNT_RST;
        end else begin
            c_st_r     <= c_st_nxt;
            st_c_r     <= st_c_nxt;
            ref_c_r    <= ref_c_nxt;
            tog_c_r    <= tog_c_nxt;
            ack_r      <= ack_nxt;
            ref_seen_r <= ref_seen_nxt;
            ratio_r    <= ratio_nxt;
            int_r      <= int_nxt;
            tally_r    <= tally_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic exp_nxt, run_nxt, done_nxt;
    // Converter pulse and its exported copy
    always_comb begin
        exp_nxt  = pulse_nxt & cfg.export_en;                  // R12
        run_nxt  = (c_st_nxt == C_WAIT) || (c_st_nxt == C_CONV);
        done_nxt = (c_st_nxt == C_DONE);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            adc_conversion_pulse <= 1'b0;
            export_drive_node    <= 1'b0;
            running              <= 1'b0;
            done                 <= 1'b0;
        end else begin
            adc_conversion_pulse <= pulse_nxt;                 // R12
            export_drive_node    <= exp_nxt;
            running              <= run_nxt;
            done                 <= done_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    conv_on_edge_a: assert property (                          // R07
        adc_conversion_pulse |-> $past(c_act))
        else $error("convert pulse without timebase edge");
    export_copy_a: assert property (                           // R12
        export_drive_node |-> adc_conversion_pulse)
        else $error("export without converter pulse");
    pause_hold_a: assert property (                            // R16
        pause_s_r |-> !samp_evt && $stable(si_cnt_r))
        else $error("sample clock during pause");
    samp_start_a: assert property (                            // R14
        (s_st_r == S_IDLE) ##1 (s_st_r == S_RUN)
        |-> $past(st_s_r) && $past(s_act))
        else $error("sample level ran without synced start");
    conv_start_a: assert property (                            // R17
        (c_st_r == C_IDLE) ##1 (c_st_r == C_WAIT)
        |-> $past(st_c_r) && $past(c_act))
        else $error("convert level ran without synced start");
    done_ref_a: assert property (                              // R09
        $rose(done) |-> ref_seen_r && tally_r >= cfg.post_cnt)
        else $error("stop before posttrigger count");
    div_sync_a: assert property (                              // R03
        (cfg.use_div && c_sync) |-> !c_act ##1 !c_act)
        else $error("sync and act edge collide");
    ext_delay_a: assert property (                             // R04
        (!cfg.use_div && c_act && $past(!cfg.use_div, DLY))
        |-> $past(c_sync, DLY))
        else $error("external timebase not delayed");
    samp_sync_a: assert property (                             // R05
        s_sync |-> !s_act ##1 !s_sync)
        else $error("sample sync edge misplaced");
    samp_evt_run_a: assert property (                          // R06
        samp_evt |-> s_st_r == S_RUN && arm)
        else $error("sample clock while idle");
endmodule : analog_input_timing_engine

// file: tb/adc_side_model.sv
`timescale 1ns/10ps
module adc_side_model #(
    parameter int HALF_C = 2,
    parameter int HALF_S = 8
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        adc_conversion_pulse,
    output logic      [1:0]  tb_lines,
    output logic      [15:0] pulse_cnt
);
    logic [7:0] c_r;
    logic [7:0] s_r;

    // --------------------------------------------------------
    // Free-running timebases on bus lines 0 and 1
    // --------------------------------------------------------
    // Both toggle on their own half periods from the same reset, line 1 four times slower than line 0
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            c_r      <= 8'h00;
            s_r      <= 8'h00;
            tb_lines <= 2'h0;
        end else begin
            c_r <= (c_r == 8'(HALF_C - 1)) ? 8'h00 : c_r + 8'h01;
            s_r <= (s_r == 8'(HALF_S - 1)) ? 8'h00 : s_r + 8'h01;
            if (c_r == 8'(HALF_C - 1)) tb_lines[0] <= ~tb_lines[0];
            if (s_r == 8'(HALF_S - 1)) tb_lines[1] <= ~tb_lines[1];
        end
    end

    // Converter side: tally every conversion pulse it receives
    always_ff @(posedge sys_clk) begin
        if (!resetn) pulse_cnt <= 16'h0000;
        else if (adc_conversion_pulse) pulse_cnt <= pulse_cnt + 16'h0001;
    end
endmodule : adc_side_model

// file: tb/test_analog_input_timing_engine.sv
`timescale 1ns/10ps
module test_analog_input_timing_engine;
    import ai_timing_pkg::*;
    logic        sys_clk, resetn, arm, sw_start;
    logic [15:0] signal_bus, pulse_cnt;
    logic [1:0]  tb_lines;
    logic [3:0]  trig;  // Lines 2..5: start, reference, pause, ext
    cfg_t        cfg;
    logic        adc_conversion_pulse, export_drive_node, running, done;
    int          num_errors, n_checks, n, p0, e0, exp_cnt;

    assign signal_bus = {10'h000, trig, tb_lines};

    analog_input_timing_engine analog_input_timing_engine_inst (
        .sys_clk(sys_clk), .resetn(resetn), .arm(arm),
        .sw_start(sw_start), .signal_bus(signal_bus), .cfg(cfg),
        .adc_conversion_pulse(adc_conversion_pulse),
        .export_drive_node(export_drive_node),
        .running(running), .done(done));

    adc_side_model adc_side_model_inst (
        .sys_clk(sys_clk), .resetn(resetn),
        .adc_conversion_pulse(adc_conversion_pulse),
        .tb_lines(tb_lines), .pulse_cnt(pulse_cnt));

    // --------------------------------------------------------
    // Clock and export monitor
    // --------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) if (export_drive_node === 1'b1) exp_cnt++;

    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic end_of_test;
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    // Cycles until the next conversion pulse, bounded
    task automatic wait_pulse(input int bound, output int cnt);
        cnt = 0;
        do begin
            tick(1);
            cnt++;
        end while (adc_conversion_pulse !== 1'b1 && cnt < bound);
        if (adc_conversion_pulse !== 1'b1) begin
            chk("pulse_timeout", 1, 0);
            end_of_test;
        end
    endtask : wait_pulse

    // Idle, then load a divided-mode base configuration
    task automatic base_cfg(input logic [15:0] div);
        arm = 1'b0; sw_start = 1'b0; trig = 4'h0;
        tick(4);
        cfg = '0;
        cfg.use_div = 1'b1;
        cfg.export_en = 1'b1;
        cfg.conv_tb_sel = 4'h0; cfg.samp_tb_sel = 4'h1;
        cfg.start_sel = 4'hf; cfg.ref_sel = 4'hf; cfg.pause_sel = 4'hf;
        cfg.samp_clk_sel = 4'hf;
        cfg.conv_div = div; cfg.samp_div = 16'h0001;
        cfg.conv_per_samp = 16'h0002;
        tick(1);
    endtask : base_cfg

    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    // Bus start line gates everything; then spacing and export copy
    task automatic t_start_gap(input logic [15:0] div, input logic exp_en);
        base_cfg(div);
        cfg.start_sel = 4'h2;
        cfg.export_en = exp_en;
        arm = 1'b1;
        p0 = pulse_cnt; e0 = exp_cnt;
        tick(60);
        chk("pulses_before_start", p0, pulse_cnt);
        chk("running_before_start", 0, running);
        trig[0] = 1'b1;
        wait_pulse(200, n);
        chk("running_after_start", 1, running);
        wait_pulse(200, n);
        chk("convert_gap", 32'(4 * div), n);
        tick(2);
        chk("export_copies", exp_en ? 32'(pulse_cnt - p0) : 0,
            32'(exp_cnt - e0));
        chk("group_pulses", 2, 32'(pulse_cnt - p0));
    endtask : t_start_gap

    // Reference trigger then posttrigger samples, whole groups
    task automatic t_reference;
        base_cfg(16'h0001);
        cfg.ref_en = 1'b1; cfg.ref_sel = 4'h3; cfg.post_cnt = 16'h0002;
        arm = 1'b1; trig[1] = 1'b1;
        p0 = pulse_cnt;
        sw_start = 1'b1;
        tick(1);
        sw_start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 600) begin
            tick(1);
            n++;
        end
        chk("done_reached", 1, done);
        chk("running_stopped", 0, running);
        // Let the model count the last pulse of the final group
        tick(1);
        chk("post_pulses", 4, 32'(pulse_cnt - p0));
        chk("whole_groups", 0, 32'(pulse_cnt - p0) % 2);
        p0 = pulse_cnt;
        tick(60);
        chk("no_pulse_after_done", p0, pulse_cnt);
        chk("done_holds", 1, done);
    endtask : t_reference

    // Pause suppresses new samples, release resumes them
    task automatic t_pause;
        base_cfg(16'h0001);
        cfg.pause_sel = 4'h4;
        arm = 1'b1; sw_start = 1'b1;
        wait_pulse(200, n);
        trig[2] = 1'b1;
        tick(40);
        p0 = pulse_cnt;
        tick(80);
        chk("paused_pulses", p0, pulse_cnt);
        trig[2] = 1'b0;
        wait_pulse(200, n);
        chk("resumed", 1, n <= 60);
    endtask : t_pause

    // External convert: no edges no pulses, a pulse lags its edge by DLY+1
    task automatic t_external;
        base_cfg(16'h0001);
        cfg.use_div = 1'b0; cfg.conv_tb_sel = 4'h5;
        cfg.conv_per_samp = 16'h0001;
        arm = 1'b1; sw_start = 1'b1;
        p0 = pulse_cnt;
        tick(80);
        chk("ext_no_edges", p0, pulse_cnt);
        // Edge train; a pulse shows only once a sample is pending
        n = 0;
        e0 = 0;
        while (e0 == 0 && n < 20) begin
            trig[3] = 1'b1;
            tick(`AIT_EXT_DLY_CYC);
            chk("ext_not_early", 0, adc_conversion_pulse);
            tick(1);
            e0 = int'(adc_conversion_pulse);
            trig[3] = 1'b0;
            tick(3);
            n++;
        end
        chk("ext_delay", 1, e0);
    endtask : t_external

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        num_errors = 0; n_checks = 0; exp_cnt = 0;
        resetn = 1'b0; arm = 1'b0; sw_start = 1'b0; trig = 4'h0;
        cfg = '0;
        tick(8);
        chk("reset_outputs", 0, {adc_conversion_pulse,
            export_drive_node, running, done});
        resetn = 1'b1;
        tick(2);
        t_start_gap(16'h0001, 1'b1);
        t_start_gap(16'h0003, 1'b0);
        t_reference;
        t_pause;
        t_external;
        end_of_test;
    end
endmodule : test_analog_input_timing_engine
